// ### logic/eil_ext_irq.sv
// Contract
// - Port option ORs the four low port pins into the shared latch.
// - Sequence starts at instruction end if latched, unmasked and enabled.
// - Vector fetch clears the latch so new requests are caught.
// - Latched request is taken once return-from-interrupt clears the mask.
// - Option selects falling-edge-only or edge-plus-low-level on the pin.
// - Edge-plus-level: low pin keeps setting the latch.
// - Edge-only: pin must rise and fall again for a new request.
// - Port pins are active high or rising, the pin active low.
// - Port pins enabled as a group, gated by the enable bit.
// - Edge-plus-level: any high port pin keeps setting the latch.
// - Edge-only: a port pin must fall and rise again to retrigger.
// - Branch-on-pin level reflects only the dedicated pin.
// - Port pins interrupt whatever their data direction.
// - Mask bit blocks external requests; reset sets it.
// - Unused status bits read as zero.
// - Writing one to the clear bit clears latch and flag.
// - Pending flag reads one while a request is pending; reset clears.
// - Enable bit permits requests when one; reset sets it.
// - Either low-power instruction sets the enable bit.
`timescale 1ns/100ps
module eil_ext_irq
    import eil_pkg::*;
#(
    parameter int PORT_W = 4
) (
    input  wire logic                  mclk,
    input  wire logic                  srst,
    input  wire logic                  irq_pin_n,
    input  wire logic [PORT_W-1:0]     port_low_pins,
    input  wire logic                  cpu_instr_end,
    input  wire logic                  cpu_vector_fetch,
    input  wire logic                  cpu_rti,
    input  wire logic                  cpu_stop,
    input  wire logic                  cpu_wait,
    output logic                       irq_start,
    output logic                       mask_bit,
    output logic                       in_service,
    output logic                       branch_pin_high,
    output logic      [15:0]           vector_hi_addr,
    output logic      [15:0]           vector_lo_addr,
    input  wire logic [EIL_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [EIL_DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic      [1:0]            s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [EIL_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic      [EIL_DATA_W-1:0] s_axi_rdata,
    output logic      [1:0]            s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready
);
    typedef struct packed {
        logic        enable;
        logic        latch;
        logic        mask;
        logic        port_opt;
        logic        level_mode;
        eil_phase_t  phase;
        logic        start;
        logic        pin_high;
        logic [15:0] vec_hi;
        logic [15:0] vec_lo;
    } eil_state_t;

    eil_state_t r;
    eil_state_t n;

    // Address match helper shared by read and write decode
    function automatic logic is_ofs(
        input logic [EIL_ADDR_W-1:0] addr,
        input logic [7:0]            ofs
    );
        is_ofs = (addr[EIL_ADDR_W-1:2] == ofs[7:2]);
    endfunction

    // Synchronised pin levels and their previous samples
    logic              pin_lvl;
    logic              pin_prev;
    logic [PORT_W-1:0] port_lvl;
    logic [PORT_W-1:0] port_prev;

    // Bus-side strobes
    logic                  wr_en;
    logic [EIL_ADDR_W-1:0] wr_addr;
    logic [EIL_DATA_W-1:0] wr_data;
    logic [3:0]            wr_strb;
    logic                  wr_err;
    logic [EIL_DATA_W-1:0] rd_data;
    logic                  rd_err;

    // Request detection terms
    logic              pin_active;
    logic              pin_fall;
    logic [PORT_W-1:0] port_rise;
    logic              pin_req;
    logic              port_req;
    logic              req_set;
    logic              sw_clear;
    logic              wr_status;
    logic              wr_config;
    logic              take;

    // Dedicated pin idles high, so its synchroniser resets high
    eil_sync #(
        .W       (1),
        .RST_VAL (1'b1)
    ) u_pin_sync (
        .mclk  (mclk),
        .srst  (srst),
        .din   (irq_pin_n),
        .level (pin_lvl),
        .prev  (pin_prev)
    );

    // Port pins idle low, so their synchroniser resets low
    eil_sync #(
        .W       (PORT_W),
        .RST_VAL ('0)
    ) u_port_sync (
        .mclk  (mclk),
        .srst  (srst),
        .din   (port_low_pins),
        .level (port_lvl),
        .prev  (port_prev)
    );

    // Register bus slave
    eil_axil_slave u_bus (
        .mclk          (mclk),
        .srst          (srst),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_en         (wr_en),
        .wr_addr       (wr_addr),
        .wr_data       (wr_data),
        .wr_strb       (wr_strb),
        .wr_err        (wr_err),
        .rd_data       (rd_data),
        .rd_err        (rd_err)
    );

    // Write decode; only byte lane 0 carries register bits
    assign wr_status = wr_en & wr_strb[0] & is_ofs(wr_addr, EIL_OFS_STATUS);
    assign wr_config = wr_en & wr_strb[0] & is_ofs(wr_addr, EIL_OFS_CONFIG);
    assign wr_err    = ~(is_ofs(wr_addr, EIL_OFS_STATUS)
                       | is_ofs(wr_addr, EIL_OFS_CONFIG));

    // Read decode; clear bit always reads zero
    always_comb begin
        rd_data = '0;
        rd_err  = 1'b0;
        if (is_ofs(s_axi_araddr, EIL_OFS_STATUS)) begin
            rd_data[EIL_ENABLE_BIT] = r.enable;
            rd_data[EIL_FLAG_BIT]   = r.latch;
        end else if (is_ofs(s_axi_araddr, EIL_OFS_CONFIG)) begin
            rd_data[EIL_PORT_BIT]  = r.port_opt;
            rd_data[EIL_LEVEL_BIT] = r.level_mode;
        end else begin
            rd_err = 1'b1;
        end
    end

    // Edge and level terms on synchronised samples
    assign pin_active = ~pin_lvl;
    assign pin_fall   = ~pin_lvl & pin_prev;
    assign port_rise  = port_lvl & ~port_prev;

    // Dedicated pin: level mode holds the request while low
    assign pin_req = r.level_mode ? pin_active : pin_fall;

    // Port group: gated by option and enable, OR of all four
    assign port_req = r.port_opt & r.enable
                    & (r.level_mode ? |port_lvl : |port_rise);

    assign req_set  = pin_req | port_req;

    // Software clear strobe; writing zero does nothing
    assign sw_clear = wr_status & wr_data[EIL_CLEAR_BIT];

    // Interrupt taken only at an instruction boundary
    assign take = cpu_instr_end & r.latch & ~r.mask & r.enable
                & (r.phase == EIL_PH_RUN);

    // Next-state logic
    always_comb begin
        n = r;
        n.start    = take;
        n.pin_high = pin_lvl;
        n.vec_hi   = EIL_VEC_HI_ADDR;
        n.vec_lo   = EIL_VEC_LO_ADDR;

        // Request latch; a new request beats any clear
        if (req_set) begin
            n.latch = 1'b1;
        end else if (cpu_vector_fetch || sw_clear) begin
            n.latch = 1'b0;
        end

        // Enable bit; low-power entry forces it on
        if (cpu_stop || cpu_wait) begin
            n.enable = 1'b1;
        end else if (wr_status) begin
            n.enable = wr_data[EIL_ENABLE_BIT];
        end

        // Source options
        if (wr_config) begin
            n.port_opt   = wr_data[EIL_PORT_BIT];
            n.level_mode = wr_data[EIL_LEVEL_BIT];
        end

        // Processor phase and mask bit
        case (r.phase)
            EIL_PH_RUN: begin
                if (take) begin
                    n.mask  = 1'b1;
                    n.phase = EIL_PH_STACK;
                end else if (cpu_rti) begin
                    n.mask = 1'b0;
                end
            end
            EIL_PH_STACK: begin
                if (cpu_vector_fetch) begin
                    n.phase = EIL_PH_SERVICE;
                end
            end
            EIL_PH_SERVICE: begin
                if (cpu_rti) begin
                    n.mask  = 1'b0;
                    n.phase = EIL_PH_RUN;
                end
            end
            default: begin
                n.phase = EIL_PH_RUN;
            end
        endcase
    end

    // State register
    always_ff @(posedge mclk) begin
        if (srst) begin
            r            <= '0;
            r.enable     <= EIL_RST_ENABLE;
            r.latch      <= EIL_RST_FLAG;
            r.mask       <= EIL_RST_MASK;
            r.port_opt   <= EIL_RST_PORT;
            r.level_mode <= EIL_RST_LEVEL;
            r.phase      <= EIL_PH_RUN;
            r.pin_high   <= 1'b1;
            r.vec_hi     <= EIL_VEC_HI_ADDR;
            r.vec_lo     <= EIL_VEC_LO_ADDR;
        end else begin
            r <= n;
        end
    end

    // Outputs straight from the state register
    assign irq_start       = r.start;
    assign mask_bit        = r.mask;
    assign in_service      = (r.phase == EIL_PH_SERVICE);
    assign branch_pin_high = r.pin_high;
    assign vector_hi_addr  = r.vec_hi;
    assign vector_lo_addr  = r.vec_lo;
endmodule

// ### common/eil_pkg.sv
package eil_pkg;

    // Bus geometry
    localparam int          EIL_ADDR_W      = 8;
    localparam int          EIL_DATA_W      = 32;

    // Register byte offsets
    localparam logic [7:0]  EIL_OFS_STATUS  = 8'h00;
    localparam logic [7:0]  EIL_OFS_CONFIG  = 8'h04;

    // Status and control field positions
    localparam int          EIL_ENABLE_BIT  = 7;
    localparam int          EIL_FLAG_BIT    = 3;
    localparam int          EIL_CLEAR_BIT   = 1;

    // Option register field positions
    localparam int          EIL_PORT_BIT    = 0;
    localparam int          EIL_LEVEL_BIT   = 1;

    // Reset values
    localparam logic        EIL_RST_ENABLE  = 1'b1;
    localparam logic        EIL_RST_FLAG    = 1'b0;
    localparam logic        EIL_RST_MASK    = 1'b1;
    localparam logic        EIL_RST_PORT    = 1'b0;
    localparam logic        EIL_RST_LEVEL   = 1'b0;

    // Service routine vector byte locations
    localparam logic [15:0] EIL_VEC_HI_ADDR = 16'h07FA;
    localparam logic [15:0] EIL_VEC_LO_ADDR = 16'h07FB;

    // Bus responses
    localparam logic [1:0]  EIL_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  EIL_RESP_SLVERR = 2'h2;

    // Processor interrupt phase
    typedef enum logic [1:0] {
        EIL_PH_RUN,
        EIL_PH_STACK,
        EIL_PH_SERVICE
    } eil_phase_t;

endpackage

// ### logic/eil_sync.sv
`timescale 1ns/100ps
module eil_sync #(
    parameter int            W       = 1,
    parameter logic [W-1:0]  RST_VAL = '0
) (
    input  wire logic         mclk,
    input  wire logic         srst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] level,
    output logic      [W-1:0] prev
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
    } eil_sync_t;

    eil_sync_t r;
    eil_sync_t n;

    // Two-stage synchroniser plus one history stage for edges
    always_comb begin
        n    = r;
        n.s1 = din;
        n.s2 = r.s1;
        n.s3 = r.s2;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            r <= {RST_VAL, RST_VAL, RST_VAL};
        end else begin
            r <= n;
        end
    end

    assign level = r.s2;
    assign prev  = r.s3;
endmodule

// ### logic/eil_axil_slave.sv
`timescale 1ns/100ps
module eil_axil_slave
    import eil_pkg::*;
(
    input  wire logic                  mclk,
    input  wire logic                  srst,
    input  wire logic [EIL_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [EIL_DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic      [1:0]            s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [EIL_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic      [EIL_DATA_W-1:0] s_axi_rdata,
    output logic      [1:0]            s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    output logic                       wr_en,
    output logic      [EIL_ADDR_W-1:0] wr_addr,
    output logic      [EIL_DATA_W-1:0] wr_data,
    output logic      [3:0]            wr_strb,
    input  wire logic                  wr_err,
    input  wire logic [EIL_DATA_W-1:0] rd_data,
    input  wire logic                  rd_err
);
    typedef struct packed {
        logic                  aw_got;
        logic                  w_got;
        logic [EIL_ADDR_W-1:0] awaddr;
        logic [EIL_DATA_W-1:0] wdata;
        logic [3:0]            wstrb;
        logic                  awready;
        logic                  wready;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  arready;
        logic                  rvalid;
        logic [EIL_DATA_W-1:0] rdata;
        logic [1:0]            rresp;
    } eil_axil_t;

    eil_axil_t r;
    eil_axil_t n;
    logic      fire;

    // Write fires once address and data are both held
    assign fire = r.aw_got & r.w_got & ~r.bvalid;

    // Channel handshakes, write commit and read capture
    always_comb begin
        n = r;
        if (s_axi_awvalid && r.awready) begin
            n.aw_got = 1'b1;
            n.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && r.wready) begin
            n.w_got = 1'b1;
            n.wdata = s_axi_wdata;
            n.wstrb = s_axi_wstrb;
        end
        if (r.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        if (fire) begin
            n.aw_got = 1'b0;
            n.w_got  = 1'b0;
            n.bvalid = 1'b1;
            n.bresp  = wr_err ? EIL_RESP_SLVERR : EIL_RESP_OKAY;
        end
        n.awready = ~n.aw_got & ~n.bvalid;
        n.wready  = ~n.w_got & ~n.bvalid;
        if (r.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        if (s_axi_arvalid && r.arready) begin
            n.rvalid = 1'b1;
            n.rdata  = rd_data;
            n.rresp  = rd_err ? EIL_RESP_SLVERR : EIL_RESP_OKAY;
        end
        n.arready = ~n.rvalid;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            r         <= '0;
            r.awready <= 1'b1;
            r.wready  <= 1'b1;
            r.arready <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign s_axi_awready = r.awready;
    assign s_axi_wready  = r.wready;
    assign s_axi_bvalid  = r.bvalid;
    assign s_axi_bresp   = r.bresp;
    assign s_axi_arready = r.arready;
    assign s_axi_rvalid  = r.rvalid;
    assign s_axi_rdata   = r.rdata;
    assign s_axi_rresp   = r.rresp;
    assign wr_en         = fire;
    assign wr_addr       = r.awaddr;
    assign wr_data       = r.wdata;
    assign wr_strb       = r.wstrb;
endmodule

// ### test/eil_key_src.sv
`timescale 1ns/100ps
module eil_key_src (
    input  wire logic [1:0] src_low,
    input  wire logic [3:0] key_hi,
    output wire logic       irq_pin_n,
    output wire logic [3:0] port_low_pins
);
    // Wired-OR pull-up pin, any source pulls it low, skewed off the clock
    assign #1.7 irq_pin_n = ~|src_low;
    // Key switches drive the port pins active high with their own skew
    assign #2.3 port_low_pins = key_hi;
endmodule

// ### test/eil_ext_irq_asserts.sv
`timescale 1ns/100ps
module eil_ext_irq_chk
    import eil_pkg::*;
#(
    parameter int PORT_W = 4
) (
    input wire logic              mclk,
    input wire logic              srst,
    input wire logic              irq_pin_n,
    input wire logic [PORT_W-1:0] port_low_pins,
    input wire logic              cpu_instr_end,
    input wire logic              cpu_vector_fetch,
    input wire logic              cpu_rti,
    input wire logic              irq_start,
    input wire logic              mask_bit,
    input wire logic              in_service,
    input wire logic              branch_pin_high,
    input wire logic [15:0]       vector_hi_addr,
    input wire logic [15:0]       vector_lo_addr,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic              s_axi_rvalid
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);
    // Entry pulse followed by the vector fetch
    sequence s_entry;
        irq_start ##1 cpu_vector_fetch;
    endsequence
    // Dedicated pin held still long enough to pass the synchroniser
    sequence s_pin_still;
        $stable(irq_pin_n) [*5];
    endsequence
    AST_VEC: assert property (vector_hi_addr == EIL_VEC_HI_ADDR && vector_lo_addr == EIL_VEC_LO_ADDR)
        else $error("vector address wrong");
    AST_BRANCH_PIN: assert property (s_pin_still |-> branch_pin_high == irq_pin_n)
        else $error("branch level not the pin");
    AST_FETCH_SERVICE: assert property (s_entry |=> in_service)
        else $error("no service after fetch");
    AST_RTI_UNMASK: assert property (cpu_rti |=> !mask_bit)
        else $error("mask not cleared by return");
    AST_MASK_HOLD: assert property (mask_bit && !cpu_rti |=> mask_bit)
        else $error("mask dropped on its own");
    AST_MASK_RISE: assert property ($rose(mask_bit) |-> irq_start)
        else $error("mask set without entry");
    AST_START_CAUSE: assert property (irq_start |-> $past(cpu_instr_end) && !$past(mask_bit))
        else $error("entry without cause");
    AST_START_PULSE: assert property (irq_start |=> !irq_start)
        else $error("entry pulse too long");
    AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    AST_RD_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
endmodule
bind eil_ext_irq eil_ext_irq_chk #(.PORT_W(PORT_W)) u_chk (.*);

// ### test/testbench.sv
`timescale 1ns/100ps
module testbench
    import eil_pkg::*;
;
    localparam logic [31:0] EN = 32'h0000_0001 << EIL_ENABLE_BIT;
    localparam logic [31:0] FL = 32'h0000_0001 << EIL_FLAG_BIT;
    localparam logic [31:0] CL = 32'h0000_0001 << EIL_CLEAR_BIT;
    localparam logic [7:0]  ST = EIL_OFS_STATUS;
    localparam logic [7:0]  CF = EIL_OFS_CONFIG;
    localparam int          EV_END = 0, EV_VF = 1, EV_RTI = 2, EV_STOP = 3, EV_WAIT = 4;
    logic        mclk, srst;
    logic [4:0]  ev;
    wire logic   cpu_instr_end = ev[EV_END], cpu_vector_fetch = ev[EV_VF], cpu_rti = ev[EV_RTI];
    wire logic   cpu_stop = ev[EV_STOP], cpu_wait = ev[EV_WAIT];
    logic        irq_start, mask_bit, in_service, branch_pin_high;
    logic [15:0] vector_hi_addr, vector_lo_addr;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb, port_low_pins, key_hi;
    logic [1:0]  s_axi_bresp, s_axi_rresp, src_low, rs;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    wire logic   irq_pin_n;
    int          err_total, samples_checked, i;
    eil_key_src key (.src_low(src_low), .key_hi(key_hi), .irq_pin_n(irq_pin_n),
        .port_low_pins(port_low_pins));
    eil_ext_irq dut (.*);
    // Free-running clock
    always #2.5 mclk = ~mclk;
    // Verdict and end of run
    task end_of_test;
        $display("mismatches %0d checks %0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task tk(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // One-cycle strobe on one processor event line
    task pulse(input int k);
        ev[k] <= 1'b1;
        @(posedge mclk);
        ev[k] <= 1'b0;
    endtask
    // Bus write: address and data offered together, each released when taken
    task axw(input logic [7:0] a, input logic [31:0] d);
        logic ah, wh, bh;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        for (i = 0; i < 50; i++) begin
            // Handshakes read mid-cycle, as they stand at the next edge
            @(negedge mclk);
            ah = s_axi_awvalid & s_axi_awready;
            wh = s_axi_wvalid & s_axi_wready;
            bh = s_axi_bvalid;
            rs = s_axi_bresp;
            @(posedge mclk);
            if (ah) s_axi_awvalid <= 0;
            if (wh) s_axi_wvalid <= 0;
            if (bh === 1'b1) break;
        end
        if (i == 50) begin
            err_total++;
            end_of_test;
        end
    endtask
    // Bus read
    task axr(input logic [7:0] a);
        logic ah, rh;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        for (i = 0; i < 50; i++) begin
            // Handshake and read data taken as they stand at the next edge
            @(negedge mclk);
            ah = s_axi_arvalid & s_axi_arready;
            rh = s_axi_rvalid;
            rd = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge mclk);
            if (ah) s_axi_arvalid <= 0;
            if (rh === 1'b1) break;
        end
        if (i == 50) begin
            err_total++;
            end_of_test;
        end
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] e);
        axr(a);
        chk(rd, e);
    endtask
    task s_reset;
        rchk(ST, EN);
        rchk(CF, 32'h0000_0000);
        chk(mask_bit, 1);
        chk(vector_hi_addr, 32'h0000_07fa);
        chk(vector_lo_addr, 32'h0000_07fb);
    endtask
    task s_edge;
        src_low <= 2'b01;
        tk(6);
        rchk(ST, EN | FL);
        chk(branch_pin_high, 0);
        axw(ST, EN);
        chk(rs, EIL_RESP_OKAY);
        rchk(ST, EN | FL);
        axw(ST, EN | CL);
        rchk(ST, EN);
        tk(6);
        rchk(ST, EN);
        src_low <= 2'b00;
        tk(6);
        src_low <= 2'b10;
        tk(6);
        rchk(ST, EN | FL);
        src_low <= 2'b00;
        axw(ST, EN | CL);
    endtask
    task s_level;
        axw(CF, 32'h0000_0002);
        src_low <= 2'b11;
        tk(6);
        axw(ST, EN | CL);
        rchk(ST, EN | FL);
        src_low <= 2'b01;
        tk(6);
        axw(ST, EN | CL);
        rchk(ST, EN | FL);
        src_low <= 2'b00;
        tk(6);
        axw(ST, EN | CL);
        rchk(ST, EN);
    endtask
    task s_port;
        axw(CF, 32'h0000_0000);
        key_hi <= 4'h4;
        tk(6);
        rchk(ST, EN);
        key_hi <= 4'h0;
        axw(CF, 32'h0000_0001);
        for (int k = 0; k < 4; k++) begin
            key_hi <= 4'h1 << k;
            tk(6);
            rchk(ST, EN | FL);
            chk(branch_pin_high, 1);
            axw(ST, EN | CL);
            tk(6);
            rchk(ST, EN);
            key_hi <= 4'h0;
            tk(4);
        end
        axw(CF, 32'h0000_0003);
        key_hi <= 4'h8;
        tk(6);
        axw(ST, EN | CL);
        rchk(ST, EN | FL);
        key_hi <= 4'h0;
        tk(6);
        axw(ST, CL);
        key_hi <= 4'h2;
        tk(6);
        rchk(ST, 32'h0000_0000);
        key_hi <= 4'h0;
        tk(6);
        pulse(EV_WAIT);
        rchk(ST, EN);
        axw(ST, 32'h0000_0000);
        pulse(EV_STOP);
        rchk(ST, EN);
        axw(CF, 32'h0000_0000);
    endtask
    task s_irq;
        axw(ST, 32'h0000_0000);
        pulse(EV_RTI);
        tk(1);
        chk(mask_bit, 0);
        src_low <= 2'b01;
        tk(6);
        pulse(EV_END);
        @(negedge mclk);
        chk(irq_start, 0);
        @(posedge mclk);
        axw(ST, EN);
        pulse(EV_END);
        @(negedge mclk);
        chk(irq_start, 1);
        chk(mask_bit, 1);
        @(posedge mclk);
        pulse(EV_VF);
        @(posedge mclk);
        chk(in_service, 1);
        rchk(ST, EN);
        src_low <= 2'b00;
        tk(4);
        src_low <= 2'b01;
        tk(6);
        rchk(ST, EN | FL);
        pulse(EV_END);
        @(negedge mclk);
        chk(irq_start, 0);
        @(posedge mclk);
        pulse(EV_RTI);
        pulse(EV_END);
        @(negedge mclk);
        chk(irq_start, 1);
        @(posedge mclk);
        src_low <= 2'b00;
        pulse(EV_VF);
        pulse(EV_RTI);
    endtask
    task s_unmapped;
        axr(8'h08);
        chk(rs, EIL_RESP_SLVERR);
        chk(rd, 32'h0000_0000);
        axw(8'h08, 32'hffff_ffff);
        chk(rs, EIL_RESP_SLVERR);
        rchk(CF, 32'h0000_0000);
    endtask
    // Main sequence
    initial begin
        mclk = 0;
        srst = 1;
        ev = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
        // Response channels always ready
        {s_axi_bready, s_axi_rready} = 2'b11;
        s_axi_awaddr = '0;
        s_axi_araddr = '0;
        s_axi_wdata = '0;
        s_axi_wstrb = 4'hf;
        src_low = 2'b00;
        key_hi = 4'h0;
        err_total = 0;
        samples_checked = 0;
        tk(10);
        srst <= 0;
        tk(3);
        s_reset;
        s_edge;
        s_level;
        s_port;
        s_irq;
        s_unmapped;
        end_of_test;
    end
endmodule
